// >>> src/crpm_pkg.sv
package crpm_pkg;

  // Clock of the block.
  localparam int CLK_PERIOD_NS = 100;

  // Internal clock divide ratio.
  localparam int DIV_RATIO = 2;

  // Internal phases per machine cycle: six states of two phases each.
  localparam int PHASES_PER_MC = 12;

  // Phase index of the reset sample point, state 5 phase 2 (zero based).
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;

  // Machine cycles that reset must be seen high before it takes effect.
  localparam logic [1:0] RESET_MIN_MC = 2'h2;

  // Reset values.
  localparam logic [7:0] PORT_RESET = 8'hff;
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SFR_RESET = 8'h00;

  // Power control register field positions.
  localparam int POWER_CONTROL_REGISTER_IDLE_BIT = 0;
  localparam int POWER_CONTROL_REGISTER_PD_BIT = 1;
  localparam int POWER_CONTROL_REGISTER_KEEP_BIT = 4;
  localparam logic [7:0] POWER_CONTROL_REGISTER_KEEP_MASK = 8'h10;

  // Power state machine, Gray coded along run, idle, power-down.
  typedef enum logic [1:0] {
    CRPM_RUN = 2'b00,
    CRPM_IDLE = 2'b01,
    CRPM_PDOWN = 2'b11
  } crpm_state_type;

  // Clock enables handed to the rest of the chip.
  typedef struct packed {
    logic core_en;
    logic periph_en;
    logic osc_run;
  } crpm_clk_type;

  // Reset-loaded values handed to the register file.
  typedef struct packed {
    logic [7:0] port0;
    logic [7:0] port1;
    logic [7:0] port2;
    logic [7:0] port3;
    logic [7:0] stack_ptr;
    logic [7:0] power_control_register;
  } crpm_regs_type;

endpackage

// >>> src/crpm_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Three-stage synchroniser; the output changes once stages two and three agree.
module crpm_sync (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic async_in,
  output logic sync_out
);

  // Synchroniser stages; stage one feeds only stage two.
  logic [2:0] stage;
  // Filtered level.
  logic level;
  logic next_level;

  // Accept a change only when the last two stages agree.
  always_comb begin
    next_level = level;
    if (stage[1] == stage[2]) begin
      next_level = stage[2];
    end
  end

  // Register the stages and the accepted level.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      stage <= 3'h0;
      level <= 1'b0;
    end else begin
      stage <= {stage[1:0], async_in};
      level <= next_level;
    end
  end

  assign sync_out = level;

endmodule

`default_nettype wire

// >>> src/crpm_top.sv
`timescale 1ns/1ps
`default_nettype none

module crpm_top (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_in,
  input wire logic irq_in,
  input wire logic power_control_register_we_in,
  input wire logic [7:0] power_control_register_wdata_in,
  output crpm_pkg::crpm_clk_type clk_en_out,
  output crpm_pkg::crpm_regs_type regs_out,
  output logic sfr_clear_out,
  output logic chip_reset_out,
  output crpm_pkg::crpm_state_type state_out
);

  // Synchronised and glitch-filtered reset pin level.
  logic reset_sync;
  // Divide-by-two phase toggle.
  logic half;
  logic next_half;
  // Phase counter inside a machine cycle.
  logic [3:0] phase;
  logic [3:0] next_phase;
  // Machine cycles seen with reset high at the sample point.
  logic [1:0] rst_count;
  logic [1:0] next_rst_count;
  // Internal reset asserted.
  logic in_reset;
  logic next_in_reset;
  // Power state.
  crpm_pkg::crpm_state_type state;
  crpm_pkg::crpm_state_type next_state;
  // Reset-loaded register values.
  crpm_pkg::crpm_regs_type regs;
  crpm_pkg::crpm_regs_type next_regs;
  // Internal phase enable.
  logic phase_en;
  // Sample strobe at state 5 phase 2.
  logic sample_en;

  // Pin synchroniser with agreement filter.
  crpm_sync u_sync (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .async_in(reset_pin_in),
    .sync_out(reset_sync)
  );

  // One internal phase every second clock; the oscillator stops in power-down.
  assign phase_en = half && (state != crpm_pkg::CRPM_PDOWN);
  assign sample_en = phase_en && (phase == crpm_pkg::SAMPLE_PHASE);

  // Divider and phase counter next values.
  always_comb begin
    next_half = ~half;
    next_phase = phase;
    if (phase_en) begin
      if (phase == 4'(crpm_pkg::PHASES_PER_MC - 1)) begin
        next_phase = 4'h0;
      end else begin
        next_phase = phase + 4'h1;
      end
    end
  end

  // Register divider state.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      half <= 1'b0;
      phase <= 4'h0;
    end else begin
      half <= next_half;
      phase <= next_phase;
    end
  end

  // Reset qualification: counted only at sample points, so glitches between them
  // and single samples never reset the chip. In power-down the oscillator is off,
  // so the pin is taken directly as the only wake source.
  always_comb begin
    next_rst_count = rst_count;
    next_in_reset = in_reset;
    if (state == crpm_pkg::CRPM_PDOWN) begin
      if (reset_sync) begin
        next_in_reset = 1'b1;
      end
    end else if (sample_en) begin
      if (!reset_sync) begin
        next_rst_count = 2'h0;
        next_in_reset = 1'b0;
      end else if (rst_count >= crpm_pkg::RESET_MIN_MC - 2'h1) begin
        next_rst_count = crpm_pkg::RESET_MIN_MC;
        next_in_reset = 1'b1;
      end else begin
        next_rst_count = rst_count + 2'h1;
      end
    end
  end

  // Register reset qualification.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_count <= 2'h0;
      in_reset <= 1'b0;
    end else begin
      rst_count <= next_rst_count;
      in_reset <= next_in_reset;
    end
  end

  // Power state and register values. Updated on every clock, not gated by the phase enable; a
  // stopped clock leaves all state intact.
  always_comb begin
    next_state = state;
    next_regs = regs;
    if (in_reset) begin
      next_state = crpm_pkg::CRPM_RUN;
      next_regs.port0 = crpm_pkg::PORT_RESET;
      next_regs.port1 = crpm_pkg::PORT_RESET;
      next_regs.port2 = crpm_pkg::PORT_RESET;
      next_regs.port3 = crpm_pkg::PORT_RESET;
      next_regs.stack_ptr = crpm_pkg::SP_RESET;
      next_regs.power_control_register = (regs.power_control_register & crpm_pkg::POWER_CONTROL_REGISTER_KEEP_MASK)
        | (crpm_pkg::SFR_RESET & ~crpm_pkg::POWER_CONTROL_REGISTER_KEEP_MASK);
    end else begin
      if (power_control_register_we_in && state == crpm_pkg::CRPM_RUN) begin
        next_regs.power_control_register = power_control_register_wdata_in;
      end
      unique case (state)
        crpm_pkg::CRPM_RUN: begin
          if (next_regs.power_control_register[crpm_pkg::POWER_CONTROL_REGISTER_PD_BIT]) begin
            next_state = crpm_pkg::CRPM_PDOWN;
          end else if (next_regs.power_control_register[crpm_pkg::POWER_CONTROL_REGISTER_IDLE_BIT]) begin
            next_state = crpm_pkg::CRPM_IDLE;
          end
        end
        crpm_pkg::CRPM_IDLE: begin
          if (irq_in) begin
            next_state = crpm_pkg::CRPM_RUN;
            next_regs.power_control_register[crpm_pkg::POWER_CONTROL_REGISTER_IDLE_BIT] = 1'b0;
          end
        end
        crpm_pkg::CRPM_PDOWN: begin
          next_state = crpm_pkg::CRPM_PDOWN;
        end
        default: begin
          next_state = crpm_pkg::CRPM_RUN;
        end
      endcase
    end
  end

  // Register power state and values; power-on reset keeps bit 4 at zero.
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= crpm_pkg::CRPM_RUN;
      regs.port0 <= crpm_pkg::PORT_RESET;
      regs.port1 <= crpm_pkg::PORT_RESET;
      regs.port2 <= crpm_pkg::PORT_RESET;
      regs.port3 <= crpm_pkg::PORT_RESET;
      regs.stack_ptr <= crpm_pkg::SP_RESET;
      regs.power_control_register <= crpm_pkg::SFR_RESET;
    end else begin
      state <= next_state;
      regs <= next_regs;
    end
  end

  // Clock enables: core only in run, peripherals in run and idle.
  assign clk_en_out.core_en = phase_en && (state == crpm_pkg::CRPM_RUN) && !in_reset;
  assign clk_en_out.periph_en = phase_en;
  assign clk_en_out.osc_run = (state != crpm_pkg::CRPM_PDOWN);
  assign regs_out = regs;
  assign sfr_clear_out = in_reset;
  assign chip_reset_out = in_reset;
  assign state_out = state;

endmodule

`default_nettype wire

// >>> verification/crpm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
// Port checker for the power-mode controller.
module crpm_monitor (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic reset_pin_in,
  input wire logic irq_in,
  input wire logic power_control_register_we_in,
  input wire logic [7:0] power_control_register_wdata_in,
  input wire crpm_pkg::crpm_clk_type clk_en_out,
  input wire crpm_pkg::crpm_regs_type regs_out,
  input wire logic sfr_clear_out,
  input wire logic chip_reset_out,
  input wire crpm_pkg::crpm_state_type state_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  // Mode decodes and an accepted write.
  wire logic idle = state_out == crpm_pkg::CRPM_IDLE;
  wire logic pd = state_out == crpm_pkg::CRPM_PDOWN;
  wire logic wr = power_control_register_we_in && state_out == crpm_pkg::CRPM_RUN && !chip_reset_out;
  // Cycles the pin has been high without a break, saturating.
  logic [4:0] hi;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      hi <= 5'h00;
    end else begin
      hi <= !reset_pin_in ? 5'h00 : (hi == 5'h1f ? hi : hi + 5'h01);
    end
  end
  property p_div;
    clk_en_out.periph_en |=> !clk_en_out.periph_en;
  endproperty
  a_div: assert property (p_div) else $error("enable pulse too long");
  property p_idle;
    wr && power_control_register_wdata_in[1:0] == 2'h1 |=> idle && !clk_en_out.core_en;
  endproperty
  a_idle: assert property (p_idle) else $error("idle entry wrong");
  property p_per;
    idle && !clk_en_out.periph_en && !chip_reset_out |=> clk_en_out.periph_en || !idle;
  endproperty
  a_per: assert property (p_per) else $error("peripheral clock stopped");
  property p_wake;
    idle && irq_in && !chip_reset_out |=> !idle && !pd && !regs_out.power_control_register[0];
  endproperty
  a_wake: assert property (p_wake) else $error("interrupt did not wake");
  property p_pd;
    wr && power_control_register_wdata_in[1] |=> pd && !clk_en_out.core_en && !clk_en_out.periph_en && !clk_en_out.osc_run;
  endproperty
  a_pd: assert property (p_pd) else $error("power-down entry wrong");
  property p_pdh;
    (pd && !reset_pin_in) [*4] |=> pd;
  endproperty
  a_pdh: assert property (p_pdh) else $error("left power-down");
  property p_rst;
    chip_reset_out && $past(chip_reset_out) |-> sfr_clear_out && regs_out.port0 == 8'hff &&
      regs_out.port3 == 8'hff && regs_out.stack_ptr == 8'h07 && !(regs_out.power_control_register & 8'hef);
  endproperty
  a_rst: assert property (p_rst) else $error("reset values wrong");
  property p_qual;
    $rose(chip_reset_out) && $past(state_out) != crpm_pkg::CRPM_PDOWN |-> hi >= 5'h14;
  endproperty
  a_qual: assert property (p_qual) else $error("reset taken too early");
  c_wake: cover property (idle && irq_in);
  c_pdwake: cover property (pd ##1 !pd);
  c_rst: cover property ($rose(chip_reset_out));
endmodule
bind crpm_top crpm_monitor mon (.clk_in, .rst_n_in, .reset_pin_in, .irq_in, .power_control_register_we_in, .power_control_register_wdata_in,
  .clk_en_out, .regs_out, .sfr_clear_out, .chip_reset_out, .state_out);
`default_nettype wire

// >>> verification/crpm_rstnet.sv
`timescale 1ns/1ps
`default_nettype none
// External reset network: a high pulse of set length, pulled low otherwise.
module crpm_rstnet (
  input wire logic clk_in,
  input wire logic go_in,
  input wire logic [7:0] len_in,
  output logic pin_out
);
  logic [7:0] left = 8'h00;
  // Counts the pulse down on the clock.
  always @(posedge clk_in) begin
    if (go_in) begin
      left <= len_in;
    end else if (left != 8'h00) begin
      left <= left - 8'h01;
    end
  end
  assign pin_out = left != 8'h00;
endmodule
`default_nettype wire

// >>> verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Bench for the clock, reset and power-mode controller.
module tb_top;
  logic clk_in = 1'b0;
  logic run = 1'b1;
  logic rst_n_in = 1'b0;
  logic irq_in = 1'b0;
  logic power_control_register_we_in = 1'b0;
  logic [7:0] power_control_register_wdata_in = 8'h00;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic seen = 1'b0;
  logic [7:0] rnd = 8'h2f;
  wire logic reset_pin_in;
  crpm_pkg::crpm_clk_type clk_en_out;
  crpm_pkg::crpm_regs_type regs_out;
  logic sfr_clear_out;
  logic chip_reset_out;
  crpm_pkg::crpm_state_type state_out;
  crpm_pkg::crpm_state_type last;
  crpm_pkg::crpm_state_type notes[$];
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  crpm_top uut (.clk_in, .rst_n_in, .reset_pin_in, .irq_in, .power_control_register_we_in, .power_control_register_wdata_in,
    .clk_en_out, .regs_out, .sfr_clear_out, .chip_reset_out, .state_out);
  crpm_rstnet net (.clk_in, .go_in(go), .len_in(len), .pin_out(reset_pin_in));
  // Clock that the bench may stop.
  initial begin
    forever #50 clk_in = run ? ~clk_in : clk_in;
  end
  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test;
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Xorshift step for the random write data.
  function automatic logic [7:0] xs(input logic [7:0] x);
    logic [7:0] y;
    y = x ^ (x << 3);
    y = y ^ (y >> 5);
    return y ^ (y << 1);
  endfunction
  task automatic wr(input logic [7:0] d);
    @(negedge clk_in);
    power_control_register_we_in = 1'b1;
    power_control_register_wdata_in = d;
    @(negedge clk_in);
    power_control_register_we_in = 1'b0;
  endtask
  task automatic pulse(input logic [7:0] n);
    @(negedge clk_in);
    go = 1'b1;
    len = n;
    @(negedge clk_in);
    go = 1'b0;
  endtask
  // Takes the oldest note whenever the state moves; also cuts a hang short.
  // Sampled on the falling edge, where the registered state has settled.
  always @(negedge clk_in) begin
    cycles++;
    if (cycles > 3000) begin
      failures++;
      stop_test();
    end
    if (rst_n_in && state_out !== last) begin
      cmp("state", 8'(notes.size() ? notes.pop_front() : 2'h2), 8'(state_out));
    end
    last <= state_out;
  end
  initial begin
    repeat (20) @(negedge clk_in);
    rst_n_in = 1'b1;
    repeat (4) @(negedge clk_in);
    rnd = xs(rnd);
    notes.push_back(crpm_pkg::CRPM_IDLE);
    wr(rnd & 8'hfc | 8'h01);
    repeat (6) @(negedge clk_in);
    run = 1'b0;
    #1025 run = 1'b1;
    @(negedge clk_in);
    cmp("mode", 8'(crpm_pkg::CRPM_IDLE), 8'(state_out));
    notes.push_back(crpm_pkg::CRPM_RUN);
    irq_in = 1'b1;
    repeat (2) @(negedge clk_in);
    irq_in = 1'b0;
    cmp("idle bit", 8'h00, 8'(regs_out.power_control_register[0]));
    pulse(8'h03);
    repeat (60) begin
      @(negedge clk_in);
      seen = seen | chip_reset_out;
    end
    cmp("glitch", 8'h00, 8'(seen));
    rnd = xs(rnd);
    notes.push_back(crpm_pkg::CRPM_PDOWN);
    wr(rnd | 8'h12);
    irq_in = 1'b1;
    repeat (10) @(negedge clk_in);
    irq_in = 1'b0;
    notes.push_back(crpm_pkg::CRPM_RUN);
    pulse(8'h3c);
    repeat (100) @(negedge clk_in);
    wr(8'hfc);
    pulse(8'h3c);
    repeat (70) begin
      @(negedge clk_in);
      if (chip_reset_out === 1'b1) break;
    end
    @(negedge clk_in);
    cmp("ports", 8'hff, regs_out.port0 & regs_out.port1 & regs_out.port2 & regs_out.port3);
    cmp("stack", 8'h07, regs_out.stack_ptr);
    cmp("power_control_register", 8'h10, regs_out.power_control_register);
    cmp("clear", 8'h01, 8'(sfr_clear_out));
    repeat (80) @(negedge clk_in);
    cmp("released", 8'h00, 8'(chip_reset_out));
    stop_test();
  end
endmodule
`default_nettype wire
